// ---- rtl/cts_control_terminal.sv ----
// Control-terminal decoder: picks one of eight settings from three pins
// and applies it. Pins are asynchronous and are synchronised here; the
// serial engine and nonvolatile storage live outside this block.
`timescale 1ns/1ps
`default_nettype none

module cts_control_terminal
    import cts_pkg::*;
(
    input  wire logic           core_clk,
    input  wire logic           rst_n,
    input  wire logic           ctrl_pin_first,
    input  wire logic           ctrl_pin_second,
    input  wire logic           ctrl_pin_third,
    input  wire logic           output_supply_ok,
    input  wire logic           nv_pin_function,
    input  wire logic           nv_commit,
    input  wire logic           set_wr_en,
    input  wire logic [2:0]     set_wr_idx,
    input  wire cts_setting_s   set_wr_data,
    input  wire cts_config_s    cfg,
    output cts_applied_s        applied,
    output logic [2:0]          active_idx,
    output logic                serial_enable
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [2:0]      pin_raw;
    wire logic [2:0] pin_sync;
    logic            sup_meta;
    logic            sup_sync;

    assign pin_raw = {ctrl_pin_third, ctrl_pin_second, ctrl_pin_first};

    // Two flops per pin; logic reads only the second stage
    for (genvar p = 0; p < CTS_IDX_W; p++) begin : g_pin_sync
        logic stage_one;
        logic stage_two;

        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                stage_one <= 1'h0;
                stage_two <= 1'h0;
            end else begin
                stage_one <= pin_raw[p];
                stage_two <= stage_one;
            end
        end

        assign pin_sync[p] = stage_two;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Supply counts as up in reset; the pins still start serial
            sup_meta <= 1'h1;
            sup_sync <= 1'h1;
        end else begin
            sup_meta <= output_supply_ok;
            sup_sync <= sup_meta;
        end
    end

    // ****************************************************************
    // Committed pin function
    // ****************************************************************
    logic pin_fn;

    // Only a committed value moves the pins; the volatile copy never does
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_fn <= CTS_PIN_SERIAL;
        end else if (nv_commit) begin
            pin_fn <= nv_pin_function;
        end
    end

    // ****************************************************************
    // Pin-mode state machine
    // ****************************************************************
    cts_mode_e mode;
    cts_mode_e next_mode;

    // A grounded output supply hands the dual-use pins back to serial use
    always_comb begin
        next_mode = mode;
        case (mode)
            CTS_ST_SERIAL: begin
                if (pin_fn == CTS_PIN_CONTROL) begin
                    next_mode = sup_sync ? CTS_ST_CONTROL : CTS_ST_FORCED;
                end
            end
            CTS_ST_CONTROL: begin
                if (pin_fn == CTS_PIN_SERIAL) begin
                    next_mode = CTS_ST_SERIAL;
                end else if (!sup_sync) begin
                    next_mode = CTS_ST_FORCED;
                end
            end
            CTS_ST_FORCED: begin
                if (pin_fn == CTS_PIN_SERIAL) begin
                    next_mode = CTS_ST_SERIAL;
                end else if (sup_sync) begin
                    next_mode = CTS_ST_CONTROL;
                end
            end
            default: next_mode = CTS_ST_SERIAL;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= CTS_ST_SERIAL;
        end else begin
            mode <= next_mode;
        end
    end

    // Taken from the next state so it moves on the same edge as mode
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_enable <= 1'h1;
        end else begin
            serial_enable <= (next_mode != CTS_ST_CONTROL);
        end
    end

    // ****************************************************************
    // Index decode
    // ****************************************************************
    logic [2:0] next_idx;

    // Serial traffic on the dual-use pins never reaches the index
    always_comb begin
        // First pin is always a control input
        next_idx = {2'h0, pin_sync[0]};
        if (mode == CTS_ST_CONTROL) begin
            next_idx = pin_sync;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_idx <= CTS_IDX_RESET;
        end else begin
            active_idx <= next_idx;
        end
    end

    // ****************************************************************
    // Setting store
    // ****************************************************************
    cts_setting_s cur;

    // Entries are not reset; all eight are loaded before the pins matter
    cts_setting_mem cts_setting_mem_i (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr_en    (set_wr_en),
        .wr_idx   (set_wr_idx),
        .wr_data  (set_wr_data),
        .rd_idx   (active_idx),
        .rd_data  (cur)
    );

    // ****************************************************************
    // Apply selected setting
    // ****************************************************************
    cts_out_e   pair_state;
    cts_out_e   single_state;
    logic [4:0] load_clamped;
    logic [7:0] freq_pick;

    always_comb begin
        freq_pick    = cur.freq_select_bit ? cfg.second_user_freq
                                           : cfg.first_user_freq;
        pair_state   = cur.pll_pair_state_bit ? cfg.pll_second_out_state
                                              : cfg.pll_first_out_state;
        single_state = cur.single_output ? cfg.y_second_out_state
                                         : cfg.y_first_out_state;
        // Load codes above the top value clamp rather than wrap
        load_clamped = (cfg.crystal_load > CTS_CLOAD_MAX) ? CTS_CLOAD_MAX
                                                          : cfg.crystal_load;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            applied <= '0;
        end else begin
            applied.spread_code   <= cur.spread_code;
            applied.ssc_mode      <= cfg.ssc_mode;
            applied.pll_freq      <= freq_pick;
            applied.pll_out_a     <= pair_state;
            applied.pll_out_b     <= pair_state;
            applied.single_output <= single_state;
            applied.power_down    <= cur.power_down;
            applied.crystal_load  <= load_clamped;
        end
    end

endmodule
`default_nettype wire

// ---- rtl/cts_pkg.sv ----
// Package for the control-terminal select block: constants, enums, structs.
// Assumes a single 25 MHz core clock and no register bus.
package cts_pkg;

    localparam int          CTS_NUM_SETTINGS = 8;
    localparam int          CTS_IDX_W        = 3;
    localparam int          CTS_SSC_W        = 3;
    localparam int          CTS_CLOAD_W      = 5;
    localparam int          CTS_CLOAD_MAX_PF = 20;
    localparam logic [4:0]  CTS_CLOAD_MAX    = 5'h14;
    localparam int          CTS_PINFN_BYTE   = 2;
    localparam int          CTS_PINFN_BIT    = 6;
    localparam logic [2:0]  CTS_SSC_OFF      = 3'h0;
    localparam logic [2:0]  CTS_IDX_RESET    = 3'h0;
    localparam logic        CTS_PIN_SERIAL   = 1'h0;
    localparam logic        CTS_PIN_CONTROL  = 1'h1;
    localparam logic        CTS_SSC_CENTER   = 1'h0;
    localparam logic        CTS_SSC_DOWN     = 1'h1;

    // Output drive states
    typedef enum logic [1:0] {
        CTS_OUT_PDOWN  = 2'h0,
        CTS_OUT_HIZ    = 2'h1,
        CTS_OUT_LOW    = 2'h2,
        CTS_OUT_ACTIVE = 2'h3
    } cts_out_e;

    // Pin-mode state machine, one-hot
    typedef enum logic [2:0] {
        CTS_ST_SERIAL  = 3'h1,
        CTS_ST_CONTROL = 3'h2,
        CTS_ST_FORCED  = 3'h4
    } cts_mode_e;

    // One control setting
    typedef struct packed {
        logic [2:0] spread_code;
        logic       freq_select_bit;
        logic       pll_pair_state_bit;
        logic       single_output;
        logic       power_down;
    } cts_setting_s;

    // Configuration held in PLL and generic storage
    typedef struct packed {
        logic       ssc_mode;
        logic [7:0] first_user_freq;
        logic [7:0] second_user_freq;
        cts_out_e   pll_first_out_state;
        cts_out_e   pll_second_out_state;
        cts_out_e   y_first_out_state;
        cts_out_e   y_second_out_state;
        logic [4:0] crystal_load;
    } cts_config_s;

    // Applied result
    typedef struct packed {
        logic [2:0] spread_code;
        logic       ssc_mode;
        logic [7:0] pll_freq;
        cts_out_e   pll_out_a;
        cts_out_e   pll_out_b;
        cts_out_e   single_output;
        logic       power_down;
        logic [4:0] crystal_load;
    } cts_applied_s;

    localparam int CTS_SET_W = $bits(cts_setting_s);

endpackage

// ---- rtl/cts_setting_mem.sv ----
// Eight-entry store of control settings with registered read data.
// Assumes writes come from configuration logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cts_setting_mem
    import cts_pkg::*;
#(
    parameter int DEPTH = CTS_NUM_SETTINGS,
    parameter int AW    = CTS_IDX_W
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire logic                 wr_en,
    input  wire logic [AW-1:0]        wr_idx,
    input  wire cts_setting_s         wr_data,
    input  wire logic [AW-1:0]        rd_idx,
    output cts_setting_s              rd_data
);
    cts_setting_s mem [DEPTH];

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_idx];
        end
    end
endmodule
`default_nettype wire

// ---- sim/cts_board_model.sv ----
// Board logic driving the three control pins.
// While busy, the dual-use pins carry changing serial traffic.
`timescale 1ns/1ps
`default_nettype none
module cts_board_model
    import cts_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic [2:0] sel,
    input  wire logic       busy,
    output logic            ctrl_pin_first,
    output logic            ctrl_pin_second,
    output logic            ctrl_pin_third
);
    logic tgl = 1'b0;
    always @(posedge core_clk) tgl <= ~tgl;
    assign ctrl_pin_first  = sel[0];
    assign ctrl_pin_second = busy ? tgl : sel[1];
    assign ctrl_pin_third  = busy ? ~tgl : sel[2];
endmodule
`default_nettype wire

// ---- sim/cts_control_terminal_properties.sv ----
// Checker for the control-terminal decoder, bound to its top module.
// Assumes one clock domain and the pipeline latencies of the design.
`timescale 1ns/1ps
`default_nettype none
module cts_control_terminal_properties
    import cts_pkg::*;
(
    input wire logic         core_clk,
    input wire logic         rst_n,
    input wire logic         ctrl_pin_first,
    input wire logic         ctrl_pin_second,
    input wire logic         ctrl_pin_third,
    input wire logic         output_supply_ok,
    input wire logic         nv_pin_function,
    input wire logic         nv_commit,
    input wire cts_config_s  cfg,
    input wire cts_applied_s applied,
    input wire logic [2:0]   active_idx,
    input wire logic         serial_enable
);
    // Cycles since reset, so the pin pipeline is known to be full
    logic [2:0] up;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) up <= 3'h0;
        else if (up != 3'h7) up <= up + 3'h1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    reset_state_a: assert property (
        up == 3'h0 |-> serial_enable && active_idx == 3'h0)
        else $error("wrong state after reset");
    idx_control_a: assert property (
        (up == 3'h7 && !serial_enable)[*5] |-> active_idx ==
        $past({ctrl_pin_third, ctrl_pin_second, ctrl_pin_first}, 3))
        else $error("index does not follow the pins");
    idx_serial_a: assert property (
        (up == 3'h7 && serial_enable)[*4] |-> active_idx[2:1] == 2'h0)
        else $error("serial pins leak into the index");
    first_pin_a: assert property (
        up == 3'h7 |-> active_idx[0] == $past(ctrl_pin_first, 3))
        else $error("first pin not decoded");
    load_clamp_a: assert property (
        up == 3'h7 |-> applied.crystal_load == ($past(cfg.crystal_load)
        > CTS_CLOAD_MAX ? CTS_CLOAD_MAX : $past(cfg.crystal_load)))
        else $error("crystal load wrong");
    ssc_mode_a: assert property (
        up == 3'h7 |-> applied.ssc_mode == $past(cfg.ssc_mode))
        else $error("spread mode wrong");
    commit_mode_a: assert property (
        output_supply_ok[*4] ##0 nv_commit |->
        ##2 serial_enable != $past(nv_pin_function, 2))
        else $error("pin function not applied on commit");
    forced_serial_a: assert property (
        !output_supply_ok[*5] |-> serial_enable)
        else $error("grounded supply did not force serial use");
endmodule
bind cts_control_terminal cts_control_terminal_properties
    cts_control_terminal_properties_i (.*);
`default_nettype wire

// ---- sim/cts_control_terminal_tb.sv ----
// Testbench for the control-terminal decoder: settings, pin modes, supply.
// Assumes the board model drives the pins and cfg changes only between picks.
`timescale 1ns/1ps
`default_nettype none
module cts_control_terminal_tb
    import cts_pkg::*;
;
    logic         core_clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         output_supply_ok = 1'b1;
    logic         nv_pin_function = 1'b0;
    logic         nv_commit = 1'b0;
    logic         set_wr_en = 1'b0;
    logic         busy = 1'b1;
    logic [2:0]   set_wr_idx = 3'h0;
    logic [2:0]   sel = 3'h0;
    cts_setting_s set_wr_data = '0;
    cts_config_s  cfg;
    cts_applied_s applied;
    logic [2:0]   active_idx;
    logic         serial_enable;
    logic         ctrl_pin_first, ctrl_pin_second, ctrl_pin_third;
    int           n_errors = 0;
    int           comparisons = 0;
    logic         exp_mode = CTS_SSC_DOWN;
    logic [4:0]   exp_load = CTS_CLOAD_MAX;
    always #20 core_clk = ~core_clk;
    cts_board_model cts_board_model_i (.core_clk, .sel, .busy,
        .ctrl_pin_first, .ctrl_pin_second, .ctrl_pin_third);
    cts_control_terminal cts_control_terminal_i (.core_clk, .rst_n,
        .ctrl_pin_first, .ctrl_pin_second, .ctrl_pin_third,
        .output_supply_ok, .nv_pin_function, .nv_commit, .set_wr_en,
        .set_wr_idx, .set_wr_data, .cfg, .applied, .active_idx,
        .serial_enable);
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic cmp_vec(input string what, input logic [23:0] exp,
                           input logic [23:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_se(input logic x);
        cmp_vec("serial_enable", 24'(x), 24'(serial_enable));
    endtask
    // Drive the pins, then check index and the applied setting
    task automatic pick(input logic [2:0] s, input logic [2:0] i);
        cts_out_e     pa;
        cts_applied_s e;
        pa = i[1] ? CTS_OUT_ACTIVE : CTS_OUT_PDOWN;
        e = {i, exp_mode, i[0] ? 8'h22 : 8'h11, pa, pa,
             i[2] ? CTS_OUT_LOW : CTS_OUT_HIZ, ^i, exp_load};
        sel = s;
        step(8);
        cmp_vec("active_idx", {21'h0, i}, {21'h0, active_idx});
        cmp_vec("applied", e, applied);
    endtask
    task automatic commit(input logic f);
        nv_pin_function = f;
        nv_commit = 1'b1;
        step(1);
        nv_commit = 1'b0;
        step(3);
    endtask
    task automatic complete_run();
        if (n_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        cfg = {CTS_SSC_DOWN, 8'h11, 8'h22, CTS_OUT_PDOWN, CTS_OUT_ACTIVE,
               CTS_OUT_HIZ, CTS_OUT_LOW, 5'h1F};
        step(8);
        rst_n = 1'b1;
        step(1);
        chk_se(1'b1);
        set_wr_en = 1'b1;
        for (int k = 0; k < 8; k++) begin
            set_wr_idx = k[2:0];
            set_wr_data = {k[2:0], k[0], k[1], k[2], ^k[2:0]};
            step(1);
        end
        set_wr_en = 1'b0;
        nv_pin_function = 1'b1;
        pick(3'h7, 3'h1);
        pick(3'h6, 3'h0);
        chk_se(1'b1);
        busy = 1'b0;
        commit(1'b1);
        chk_se(1'b0);
        for (int k = 0; k < 8; k++) begin
            pick(k[2:0], k[2:0]);
        end
        output_supply_ok = 1'b0;
        busy = 1'b1;
        pick(3'h7, 3'h1);
        chk_se(1'b1);
        output_supply_ok = 1'b1;
        busy = 1'b0;
        pick(3'h5, 3'h5);
        cfg.ssc_mode = CTS_SSC_CENTER;
        cfg.crystal_load = 5'h0A;
        exp_mode = CTS_SSC_CENTER;
        exp_load = 5'h0A;
        pick(3'h2, 3'h2);
        commit(1'b0);
        chk_se(1'b1);
        complete_run();
    end
endmodule
`default_nettype wire
